//--- rtl/fbs_pkg.sv
package fbs_pkg;
	// Array geometry: 256K words of two 9-bit lanes
	localparam int ADDR_W = 18;
	localparam int DEPTH = 262144;
	localparam int LANES = 2;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int WORD_W = 18;
	localparam int CNT_W = 2;
	localparam int DATA_W = 16;

	// Burst counter constants
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_STEP = 2'h1;

	// Reset values of pin outputs
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [1:0] PAR_RST = 2'h0;

	// Selection state
	typedef enum logic [0:0] {
		FBS_DESEL = 1'b0,
		FBS_SEL = 1'b1
	} fbs_state_e;
endpackage

//--- rtl/fbs_burst_ctr.sv
`timescale 1ns/10ps
module fbs_burst_ctr (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [fbs_pkg::CNT_W-1:0] seed,
	input wire logic step,
	input wire logic interleave,
	output logic [fbs_pkg::CNT_W-1:0] next_count
);
	import fbs_pkg::*;

	logic [CNT_W-1:0] base;
	logic [CNT_W-1:0] phase;
	logic [CNT_W-1:0] next_base;
	logic [CNT_W-1:0] next_phase;

	// Seed and step position; the order only changes how they combine
	assign next_base = load ? seed : base;
	assign next_phase = load ? CNT_ZERO : (step ? phase + CNT_STEP : phase);
	// Interleaved XORs the step index, linear adds it and wraps
	assign next_count = interleave ? (next_base ^ next_phase) : (next_base + next_phase);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			base <= CNT_ZERO;
			phase <= CNT_ZERO;
		end else begin
			base <= next_base;
			phase <= next_phase;
		end
	end
endmodule

//--- rtl/fbs_store.sv
`timescale 1ns/10ps
module fbs_store (
	input wire logic mclk,
	input wire logic [fbs_pkg::LANES-1:0] wr_lane,
	input wire logic [fbs_pkg::ADDR_W-1:0] wr_index,
	input wire logic [fbs_pkg::WORD_W-1:0] wr_word,
	input wire logic [fbs_pkg::ADDR_W-1:0] rd_index,
	output logic [fbs_pkg::WORD_W-1:0] rd_word
);
	import fbs_pkg::*;

	// One array per lane so each lane has a single writer; no reset, contents survive sleep
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [LANE_W-1:0] cells [0:DEPTH-1];
			always_ff @(posedge mclk) begin
				if (wr_lane[g]) begin
					cells[wr_index] <= wr_word[g*LANE_W +: LANE_W];
				end
			end
			// Read is combinational so the next address flows straight to the output flops
			assign rd_word[g*LANE_W +: LANE_W] = cells[rd_index];
		end
	endgenerate
endmodule

//--- rtl/fbs_port.sv
// Operation
// - Address registered on strobe with chips selected
// - Low two address bits seed burst counter
// - Lane write needs select and lane enable
// - All-lanes write overrides lane selects
// - Step input advances burst counter each edge of a held burst, not at a strobe load
// - Primary select high makes processor strobe ignored
// - Either strobe loads address and counter
// - Both strobes low: processor strobe wins
// - Output enable low drives, high tristates pins
// - Output enable masked first read from deselect
// - Sleep input idles device, keeps data
// - Input data captured at rising edge
// - Read data from address registered at same edge
// - Order strap low linear, high interleaved
// - Interleaved order XORs start with step
// - Linear order increments, wraps modulo four
// - Processor-started access ignores writes first cycle
// - Detected write tristates data whatever enable
`timescale 1ns/10ps
module fbs_port (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [fbs_pkg::ADDR_W-1:0] addr,
	input wire logic chip_select_primary_n,
	input wire logic chip_select_high,
	input wire logic chip_select_third_n,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic lane_a_write_sel_n,
	input wire logic lane_b_write_sel_n,
	input wire logic all_lanes_write_n,
	input wire logic lane_write_enable_n,
	input wire logic out_enable_n,
	input wire logic sleep_request,
	input wire logic burst_order_interleave,
	input wire logic [fbs_pkg::DATA_W-1:0] data_io_in,
	output logic [fbs_pkg::DATA_W-1:0] data_io_out,
	output logic data_io_oe,
	input wire logic [fbs_pkg::LANES-1:0] parity_io_in,
	output logic [fbs_pkg::LANES-1:0] parity_io_out,
	output logic parity_io_oe
);
	import fbs_pkg::*;

	logic rst_meta;
	logic rst_n;
	fbs_state_e state;
	fbs_state_e next_state;
	logic [ADDR_W-1:CNT_W] addr_hi;
	logic drive;

	wire sel_ok;
	wire proc_take;
	wire ctrl_take;
	wire addr_load;
	wire load_sel;
	wire held;
	wire cycle_active;
	wire step_req;
	wire write_now;
	wire read_now;
	wire first_read;
	wire next_drive;
	wire [LANES-1:0] lane_sel_n;
	wire [LANES-1:0] lane_we;
	wire [LANES-1:0] wr_lane;
	wire [CNT_W-1:0] next_low;
	wire [ADDR_W-1:CNT_W] next_hi;
	wire [ADDR_W-1:0] next_index;
	wire [WORD_W-1:0] pin_word;
	wire [WORD_W-1:0] rd_word;
	wire [DATA_W-1:0] rd_data;
	wire [LANES-1:0] rd_par;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Start decode; sleep blocks every new access so the array is left alone
	assign sel_ok = !chip_select_primary_n & chip_select_high & !chip_select_third_n;
	assign proc_take = !sleep_request & !proc_addr_strobe_n & !chip_select_primary_n;
	assign ctrl_take = !sleep_request & !ctrl_addr_strobe_n & !proc_take;
	assign addr_load = proc_take | ctrl_take;
	assign load_sel = addr_load & sel_ok;
	assign held = !sleep_request & !addr_load & (state == FBS_SEL);
	assign cycle_active = load_sel | held;
	assign step_req = held & !burst_step_n;

	// Lane write enables; the all-lanes input needs neither select nor enable
	assign lane_sel_n = {lane_b_write_sel_n, lane_a_write_sel_n};
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_we[g] = !all_lanes_write_n | (!lane_write_enable_n & !lane_sel_n[g]);
			assign pin_word[g*LANE_W +: LANE_W] = {parity_io_in[g], data_io_in[g*BYTE_W +: BYTE_W]};
			assign rd_data[g*BYTE_W +: BYTE_W] = rd_word[g*LANE_W +: BYTE_W];
			assign rd_par[g] = rd_word[g*LANE_W + BYTE_W];
		end
	endgenerate

	// A processor-strobe start never writes in its own cycle
	assign write_now = cycle_active & !proc_take & (|lane_we);
	assign wr_lane = lane_we & {LANES{write_now}};
	assign read_now = cycle_active & !write_now;
	assign first_read = load_sel & (state == FBS_DESEL) & read_now;

	// Enable is sampled, so the pins follow it one edge late; writes force tristate
	assign next_drive = read_now & !out_enable_n & !first_read;

	// Address of the word handled at this edge
	assign next_hi = load_sel ? addr[ADDR_W-1:CNT_W] : addr_hi;
	assign next_index = {next_hi, next_low};

	// Selection state follows the last accepted strobe; sleep drops it
	always_comb begin
		next_state = state;
		unique case (state)
			FBS_DESEL: begin
				if (load_sel) begin
					next_state = FBS_SEL;
				end
			end
			FBS_SEL: begin
				if (sleep_request | (addr_load & !sel_ok)) begin
					next_state = FBS_DESEL;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FBS_DESEL;
		end else begin
			state <= next_state;
		end
	end

	// Upper address bits held across the burst
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_hi <= '0;
		end else if (load_sel) begin
			addr_hi <= addr[ADDR_W-1:CNT_W];
		end
	end

	// Output word registered at the address edge, giving flow-through timing
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_io_out <= DATA_RST;
			parity_io_out <= PAR_RST;
			drive <= 1'b0;
		end else begin
			if (read_now) begin
				data_io_out <= rd_data;
				parity_io_out <= rd_par;
			end
			drive <= next_drive;
		end
	end

	// Both pin groups share one enable
	assign data_io_oe = drive;
	assign parity_io_oe = drive;

	// Burst order strap is used live; it must stay static
	fbs_burst_ctr u_ctr (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(load_sel),
		.seed(addr[CNT_W-1:0]),
		.step(step_req),
		.interleave(burst_order_interleave),
		.next_count(next_low)
	);

	// Write data taken from the pins at the same edge
	fbs_store u_store (
		.mclk(mclk),
		.wr_lane(wr_lane),
		.wr_index(next_index),
		.wr_word(pin_word),
		.rd_index(next_index),
		.rd_word(rd_word)
	);
endmodule

//--- tb/fbs_port_assertions.sv
`timescale 1ns/10ps
module fbs_port_checker (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic chip_select_primary_n,
	input wire logic chip_select_high,
	input wire logic chip_select_third_n,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic all_lanes_write_n,
	input wire logic out_enable_n,
	input wire logic sleep_request,
	input wire logic [fbs_pkg::DATA_W-1:0] data_io_out,
	input wire logic data_io_oe,
	input wire logic parity_io_oe
);
	// Fully selected processor start; controller load with a bad select
	wire logic rd_go = !proc_addr_strobe_n && !chip_select_primary_n && chip_select_high && !chip_select_third_n;
	wire logic bad_sel = !ctrl_addr_strobe_n && proc_addr_strobe_n && !chip_select_high;
	wire logic quiet = (proc_addr_strobe_n || chip_select_primary_n) && ctrl_addr_strobe_n && all_lanes_write_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sleep_off_a: assert property (sleep_request |=> !data_io_oe)
		else $error("Driven in sleep");
	oe_off_a: assert property (out_enable_n |=> !data_io_oe)
		else $error("Driven, enable high");
	lanes_pair_a: assert property (data_io_oe == parity_io_oe)
		else $error("Lane enables differ");
	write_tri_a: assert property (proc_addr_strobe_n && !all_lanes_write_n |=> !data_io_oe)
		else $error("Driven on write");
	desel_a: assert property (bad_sel |=> !data_io_oe)
		else $error("Driven when deselected");
	first_mask_a: assert property (bad_sel ##1 rd_go |=> !data_io_oe)
		else $error("Enable not masked");
	oe_hold_a: assert property (rd_go && !out_enable_n && !sleep_request && data_io_oe |=> data_io_oe)
		else $error("Read lost enable");
	hold_data_a: assert property (quiet && burst_step_n && data_io_oe |=> $stable(data_io_out))
		else $error("Data moved");
	// Main traffic shapes
	cover property (!proc_addr_strobe_n && !ctrl_addr_strobe_n);
	cover property (!burst_step_n && data_io_oe);
	cover property (sleep_request);
endmodule
bind fbs_port fbs_port_checker u_fbs_port_checker (.*);

//--- tb/fbs_host.sv
`timescale 1ns/10ps
module fbs_host (
	input wire logic mclk,
	input wire logic drv,
	input wire logic [17:0] word,
	input wire logic [15:0] data_io_out,
	input wire logic [1:0] parity_io_out,
	input wire logic data_io_oe,
	output logic [15:0] data_io_in,
	output logic [1:0] parity_io_in
);
	// Released bus flips each cycle so stale data never looks written
	logic [17:0] last = 18'h0;
	wire logic [17:0] bus = drv ? word : data_io_oe ? {parity_io_out[1], data_io_out[15:8], parity_io_out[0],
		data_io_out[7:0]} : ~last;
	always @(posedge mclk) last <= bus;
	assign {parity_io_in[1], data_io_in[15:8], parity_io_in[0], data_io_in[7:0]} = bus;
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
`define FBS_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error %0t: %h %h", $time, g, e); end end
module testbench;
	import fbs_pkg::*;
	// c: strobes p/c, selects, step, all, lane en, lanes b/a, oe, order, sleep, drive, want oe, check
	typedef struct packed {logic [15:0] c; logic [ADDR_W-1:0] a; logic [WORD_W-1:0] d;} fbs_row_s;
	localparam fbs_row_s IDLE = {16'hD7E0, 36'h0};
	localparam fbs_row_s TOP_RD = {16'h97C1, 18'h3FFFF, 18'h05A5A};
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic proc_addr_strobe_n, ctrl_addr_strobe_n, chip_select_primary_n, chip_select_high, chip_select_third_n, drv;
	logic burst_step_n, all_lanes_write_n, lane_write_enable_n, lane_b_write_sel_n, lane_a_write_sel_n;
	logic out_enable_n, burst_order_interleave, sleep_request, data_io_oe, parity_io_oe;
	logic [ADDR_W-1:0] addr;
	logic [WORD_W-1:0] word;
	logic [DATA_W-1:0] data_io_in, data_io_out;
	logic [LANES-1:0] parity_io_in, parity_io_out;
	int err_count = 0;
	int comparisons = 0;
	fbs_row_s rows [20] = '{
		{16'h95E4, 18'h4, 18'h1A004},
		{16'h95E4, 18'h5, 18'h1A005},
		{16'h95E4, 18'h6, 18'h1A006},
		{16'h95E4, 18'h7, 18'h1A007},
		{16'h87C0, 18'h0, 18'h0},
		{16'h57C1, 18'h5, 18'h1A005},
		{16'hD3C3, 18'h0, 18'h1A006},
		{16'hD3C3, 18'h0, 18'h1A007},
		{16'hD3C3, 18'h0, 18'h1A004},
		{16'h57D3, 18'h5, 18'h1A005},
		{16'hD3D3, 18'h0, 18'h1A004},
		{16'hD3D3, 18'h0, 18'h1A007},
		{16'h15E1, 18'h6, 18'h1A006},
		{16'hD684, 18'h0, 18'h3FFFF},
		{16'h9721, 18'h7, 18'h1A007},
		{16'h97C3, 18'h6, 18'h1A1FF},
		{16'h77C3, 18'h4, 18'h1A1FF},
		{16'h95E4, 18'h3FFFF, 18'h05A5A},
		{16'h57C3, 18'h3FFFF, 18'h05A5A},
		{16'h57C9, 18'h4, 18'h05A5A}
	};
	fbs_port u_fbs_port (.*);
	fbs_host u_fbs_host (.*);
	initial forever #5 mclk = ~mclk;
	task automatic drive(input fbs_row_s r);
		{proc_addr_strobe_n, ctrl_addr_strobe_n, chip_select_primary_n, chip_select_high, chip_select_third_n, burst_step_n,
			all_lanes_write_n, lane_write_enable_n, lane_b_write_sel_n, lane_a_write_sel_n, out_enable_n,
			burst_order_interleave, sleep_request, drv} <= r.c[15:2];
		addr <= r.a;
		word <= r.d;
	endtask
	task automatic check(input fbs_row_s r);
		logic [WORD_W-1:0] got;
		got = {parity_io_out[1], data_io_out[15:8], parity_io_out[0], data_io_out[7:0]};
		`FBS_CHK(data_io_oe, r.c[1]);
		`FBS_CHK(parity_io_oe, r.c[1]);
		if (r.c[0]) `FBS_CHK(got, r.d);
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Rows, then a reset in mid-run; memory must survive it
	initial begin
		drive(IDLE);
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i <= 20; i++) begin
			drive(i < 20 ? rows[i] : IDLE);
			@(negedge mclk);
			if (i > 0) begin
				check(rows[i - 1]);
				$display("Row %0d done", i - 1);
			end
			@(posedge mclk);
		end
		$display("Row tests done");
		arst_n <= 1'b0;
		@(negedge mclk);
		`FBS_CHK({data_io_oe, data_io_out}, 17'h0);
		@(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		drive(TOP_RD);
		@(posedge mclk);
		drive(IDLE);
		@(negedge mclk);
		check(TOP_RD);
		$display("Reset test done");
		results();
	end
	// About 39 cycles expected; over ten times that means a hang
	initial begin
		#4500;
		err_count++;
		results();
	end
endmodule
